// file: uart_hold_pkg.sv
`default_nettype none
package uart_hold_pkg;
    // bit timing, 8 data bits, no parity, one stop bit
    localparam int CLK_HZ = 100_000_000;
    localparam int BIT_RATE_HZ = 115_200;
    localparam int OVS_RATE = 16;
    localparam int OVS_DIV = CLK_HZ / (OVS_RATE * BIT_RATE_HZ);
    localparam logic [15:0] OVS_LAST = 16'(OVS_DIV - 1);
    localparam logic [3:0] TICKS_MID = 4'h7;
    localparam logic [3:0] TICKS_LAST = 4'hf;
    localparam logic [2:0] BITS_LAST = 3'h7;

    // register addresses on the parallel bus
    localparam logic [2:0] ADR_HOLD = 3'h0;
    localparam logic [2:0] ADR_IRQ_MASK = 3'h1;
    localparam logic [2:0] ADR_FIFO_CTL = 3'h2;
    localparam logic [2:0] ADR_LINE_CTL = 3'h3;
    localparam logic [2:0] ADR_LINE_STAT = 3'h5;

    // field positions
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_FLUSH = 1;
    localparam int FC_TX_FLUSH = 2;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_TRIG_LO = 6;
    localparam int FC_TRIG_HI = 7;
    localparam int LC_DIV_ACCESS = 7;
    localparam int IE_RX_DATA = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE_STAT = 2;
    localparam int IE_MODEM = 3;
    localparam int RXE_FRAME = 8;
    localparam int RXE_BREAK = 9;

    // reset values
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] FIFO_CTL_RST = 8'h00;
    localparam logic [7:0] LINE_CTL_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // buffer shape
    localparam int DATA_W = 8;
    localparam int RX_ENTRY_W = 10;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;

    // receive trigger levels selected by the two trigger bits
    localparam logic [3:0] TRIG_LVL0 = 4'h1;
    localparam logic [3:0] TRIG_LVL1 = 4'h2;
    localparam logic [3:0] TRIG_LVL2 = 4'h4;
    localparam logic [3:0] TRIG_LVL3 = 4'h7;

    // interrupt source identities, highest priority first
    localparam logic [2:0] SRC_LINE_STAT = 3'h3;
    localparam logic [2:0] SRC_RX_DATA = 3'h2;
    localparam logic [2:0] SRC_TX_EMPTY = 3'h1;
    localparam logic [2:0] SRC_MODEM = 3'h0;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : uart_hold_pkg
`default_nettype wire

// file: uart_hold.sv
`timescale 1ns/10ps
`default_nettype none

module fifo_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    localparam int AW = $clog2(DEPTH),
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CW-1:0] count
);
    // depth must be a power of two so the pointers wrap by themselves
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign count = count_ff;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            case ({push, pop})
                2'b10: begin
                    count_ff <= count_ff + 1'b1;
                end
                2'b01: begin
                    count_ff <= count_ff - 1'b1;
                end
                default: begin
                    count_ff <= count_ff;
                end
            endcase
        end
    end
endmodule : fifo_buf

module uart_hold
    import uart_hold_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic modem_delta,
    output logic int_out,
    output logic tx_space_ready_n,
    output logic rx_data_ready_n
);
    function automatic logic [3:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'b00: trig_level = TRIG_LVL0;
            2'b01: trig_level = TRIG_LVL1;
            2'b10: trig_level = TRIG_LVL2;
            default: trig_level = TRIG_LVL3;
        endcase
    endfunction : trig_level

    logic [7:0] irq_mask_ff;
    logic [7:0] fifo_ctl_ff;
    logic [7:0] line_ctl_ff;
    logic [7:0] rdata_ff;
    logic overrun_ff;
    logic [CNT_W-1:0] err_cnt_ff;
    logic int_ff;
    logic tx_space_ready_n_n_ff;
    logic rx_data_ready_n_n_ff;
    logic [15:0] ovs_cnt_ff;
    logic [2:0] rx_sync_ff;
    logic rx_line_ff;
    tx_state_t tx_st_ff;
    logic [3:0] tx_tick_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_shift_ff;
    logic tx_pin_ff;
    rx_state_t rx_st_ff;
    logic [3:0] rx_tick_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_shift_ff;

    // bus decode
    wire div_access = line_ctl_ff[LC_DIV_ACCESS];
    wire sel_hold = (bus_addr == ADR_HOLD) & ~div_access;
    wire sel_mask = (bus_addr == ADR_IRQ_MASK) & ~div_access;
    wire sel_fctl = (bus_addr == ADR_FIFO_CTL);
    wire sel_lctl = (bus_addr == ADR_LINE_CTL);
    wire sel_lstat = (bus_addr == ADR_LINE_STAT);
    wire wr_fctl = bus_wr & sel_fctl;
    wire fifo_en = fifo_ctl_ff[FC_ENABLE];
    wire dma_mode1 = fifo_en & fifo_ctl_ff[FC_DMA_MODE];
    wire en_change = wr_fctl & (bus_wdata[FC_ENABLE] != fifo_en);
    wire tx_flush = (wr_fctl & bus_wdata[FC_TX_FLUSH]) | en_change;
    wire rx_flush = (wr_fctl & bus_wdata[FC_RX_FLUSH]) | en_change;
    wire [3:0] trig_lvl = trig_level(fifo_ctl_ff[FC_TRIG_HI:FC_TRIG_LO]);

    // oversampling tick
    wire ovs_tick = (ovs_cnt_ff == OVS_LAST);

    // transmit buffer
    logic tx_in_ready;
    logic tx_out_valid;
    logic [DATA_W-1:0] tx_out_data;
    wire tx_space = fifo_en ? tx_in_ready : ~tx_out_valid;
    wire tx_write = bus_wr & sel_hold & tx_space;
    wire tx_take = (tx_st_ff == TX_IDLE);
    wire tx_hold_empty = ~tx_out_valid;
    wire tx_all_empty = tx_hold_empty & tx_take;

    fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(tx_flush),
        .in_valid(tx_write),
        .in_ready(tx_in_ready),
        .in_data(bus_wdata),
        .out_valid(tx_out_valid),
        .out_ready(tx_take),
        .out_data(tx_out_data),
        .count()
    );

    // receive buffer
    logic rx_in_ready;
    logic rx_out_valid;
    logic [RX_ENTRY_W-1:0] rx_out_data;
    logic [CNT_W-1:0] rx_count;
    wire rx_bit_end = ovs_tick & (rx_tick_ff == TICKS_LAST);
    wire rx_done = (rx_st_ff == RX_STOP) & rx_bit_end;
    wire rx_frame_err = ~rx_line_ff;
    wire rx_break = rx_frame_err & (rx_shift_ff == ZERO_BYTE);
    wire [RX_ENTRY_W-1:0] rx_entry = {rx_break, rx_frame_err, rx_shift_ff};
    wire rx_space = fifo_en ? rx_in_ready : ~rx_out_valid;
    wire rx_push = rx_done & rx_space;
    wire rx_overrun = rx_done & ~rx_space;
    wire rx_read = bus_rd & sel_hold;
    wire rx_pop = rx_read & rx_out_valid;
    wire push_err = rx_push & (rx_break | rx_frame_err);
    wire pop_err = rx_pop & (rx_out_data[RXE_FRAME] | rx_out_data[RXE_BREAK]);

    fifo_buf #(.WIDTH(RX_ENTRY_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(rx_flush),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_entry),
        .out_valid(rx_out_valid),
        .out_ready(rx_read),
        .out_data(rx_out_data),
        .count(rx_count)
    );

    // line status
    wire top_frame = rx_out_valid & rx_out_data[RXE_FRAME];
    wire top_break = rx_out_valid & rx_out_data[RXE_BREAK];
    wire [7:0] line_stat = {
        (err_cnt_ff != '0),
        tx_all_empty,
        tx_hold_empty,
        top_break,
        top_frame,
        1'b0,
        overrun_ff,
        rx_out_valid
    };

    // interrupt sources; all mask bits clear leaves only polling
    wire rx_at_trig = (rx_count >= trig_lvl);
    wire ls_pend = irq_mask_ff[IE_LINE_STAT] & (overrun_ff | top_frame | top_break);
    wire rx_pend = irq_mask_ff[IE_RX_DATA] & (fifo_en ? rx_at_trig : rx_out_valid);
    wire tx_pend = irq_mask_ff[IE_TX_EMPTY] & tx_hold_empty;
    wire ms_pend = irq_mask_ff[IE_MODEM] & modem_delta;
    wire any_pend = ls_pend | rx_pend | tx_pend | ms_pend;
    wire [2:0] src_id = ls_pend ? SRC_LINE_STAT : rx_pend ? SRC_RX_DATA
        : tx_pend ? SRC_TX_EMPTY : SRC_MODEM;
    wire [7:0] src_stat = {fifo_en, fifo_en, 2'b00, src_id, ~any_pend};

    wire [7:0] rd_sel = sel_hold ? rx_out_data[DATA_W-1:0]
        : sel_mask ? irq_mask_ff
        : sel_fctl ? src_stat
        : sel_lctl ? line_ctl_ff
        : sel_lstat ? line_stat : ZERO_BYTE;

    // dma ready outputs
    logic nxt_tx_space_ready_n_n;
    logic nxt_rx_data_ready_n_n;
    always_comb begin
        if (!dma_mode1) begin
            nxt_tx_space_ready_n_n = ~tx_space;
            nxt_rx_data_ready_n_n = ~rx_out_valid;
        end else begin
            nxt_tx_space_ready_n_n = tx_hold_empty ? 1'b0 : ~tx_in_ready ? 1'b1 : tx_space_ready_n_n_ff;
            nxt_rx_data_ready_n_n = rx_at_trig ? 1'b0 : ~rx_out_valid ? 1'b1 : rx_data_ready_n_n_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_ff <= IRQ_MASK_RST;
            fifo_ctl_ff <= FIFO_CTL_RST;
            line_ctl_ff <= LINE_CTL_RST;
        end else begin
            if (bus_wr & sel_mask) begin
                irq_mask_ff <= {4'h0, bus_wdata[IE_MODEM:IE_RX_DATA]};
            end
            if (wr_fctl) begin
                fifo_ctl_ff <= {bus_wdata[FC_TRIG_HI:FC_TRIG_LO], 2'b00, bus_wdata[FC_DMA_MODE], 2'b00,
                    bus_wdata[FC_ENABLE]};
            end
            if (bus_wr & sel_lctl) begin
                line_ctl_ff <= bus_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= ZERO_BYTE;
            int_ff <= 1'b0;
            tx_space_ready_n_n_ff <= 1'b0;
            rx_data_ready_n_n_ff <= 1'b1;
        end else begin
            rdata_ff <= bus_rd ? rd_sel : rdata_ff;
            int_ff <= any_pend;
            tx_space_ready_n_n_ff <= nxt_tx_space_ready_n_n;
            rx_data_ready_n_n_ff <= nxt_rx_data_ready_n_n;
        end
    end

    // overrun: a new overrun in the read cycle wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_ff <= 1'b0;
        end else begin
            overrun_ff <= rx_overrun | (overrun_ff & ~(bus_rd & sel_lstat));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_cnt_ff <= '0;
        end else if (rx_flush) begin
            err_cnt_ff <= '0;
        end else if (push_err & ~pop_err) begin
            err_cnt_ff <= err_cnt_ff + 1'b1;
        end else if (pop_err & ~push_err) begin
            err_cnt_ff <= err_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovs_cnt_ff <= '0;
        end else begin
            ovs_cnt_ff <= ovs_tick ? '0 : ovs_cnt_ff + 1'b1;
        end
    end

    // transmitter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_st_ff <= TX_IDLE;
            tx_tick_ff <= '0;
            tx_bit_ff <= '0;
            tx_shift_ff <= ZERO_BYTE;
            tx_pin_ff <= 1'b1;
        end else begin
            case (tx_st_ff)
                TX_IDLE: begin
                    tx_pin_ff <= 1'b1;
                    if (tx_out_valid) begin
                        tx_shift_ff <= tx_out_data;
                        tx_tick_ff <= '0;
                        tx_st_ff <= TX_START;
                    end
                end
                TX_START: begin
                    tx_pin_ff <= 1'b0;
                    if (ovs_tick) begin
                        tx_tick_ff <= tx_tick_ff + 1'b1;
                        if (tx_tick_ff == TICKS_LAST) begin
                            tx_bit_ff <= '0;
                            tx_st_ff <= TX_DATA;
                        end
                    end
                end
                TX_DATA: begin
                    tx_pin_ff <= tx_shift_ff[0];
                    if (ovs_tick) begin
                        tx_tick_ff <= tx_tick_ff + 1'b1;
                        if (tx_tick_ff == TICKS_LAST) begin
                            tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                            tx_bit_ff <= tx_bit_ff + 1'b1;
                            if (tx_bit_ff == BITS_LAST) begin
                                tx_st_ff <= TX_STOP;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    tx_pin_ff <= 1'b1;
                    if (ovs_tick) begin
                        tx_tick_ff <= tx_tick_ff + 1'b1;
                        if (tx_tick_ff == TICKS_LAST) begin
                            tx_st_ff <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_ff <= TX_IDLE;
                end
            endcase
        end
    end

    // receive pin: a change counts once the second and third stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sync_ff <= 3'h7;
            rx_line_ff <= 1'b1;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], serial_in};
            if (rx_sync_ff[1] == rx_sync_ff[2]) begin
                rx_line_ff <= rx_sync_ff[2];
            end
        end
    end

    wire rx_fall = rx_line_ff & (rx_sync_ff[1] == rx_sync_ff[2]) & ~rx_sync_ff[2];

    // receiver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_st_ff <= RX_IDLE;
            rx_tick_ff <= '0;
            rx_bit_ff <= '0;
            rx_shift_ff <= ZERO_BYTE;
        end else begin
            case (rx_st_ff)
                RX_IDLE: begin
                    rx_tick_ff <= '0;
                    if (rx_fall) begin
                        rx_st_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (ovs_tick) begin
                        rx_tick_ff <= rx_tick_ff + 1'b1;
                        if (rx_tick_ff == TICKS_MID) begin
                            rx_tick_ff <= '0;
                            rx_bit_ff <= '0;
                            rx_st_ff <= rx_line_ff ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (ovs_tick) begin
                        rx_tick_ff <= rx_tick_ff + 1'b1;
                        if (rx_tick_ff == TICKS_LAST) begin
                            rx_shift_ff <= {rx_line_ff, rx_shift_ff[7:1]};
                            rx_bit_ff <= rx_bit_ff + 1'b1;
                            if (rx_bit_ff == BITS_LAST) begin
                                rx_st_ff <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (ovs_tick) begin
                        rx_tick_ff <= rx_tick_ff + 1'b1;
                    end
                    if (rx_bit_end) begin
                        rx_st_ff <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st_ff <= RX_IDLE;
                end
            endcase
        end
    end

    assign bus_rdata = rdata_ff;
    assign serial_out = tx_pin_ff;
    assign int_out = int_ff;
    assign tx_space_ready_n = tx_space_ready_n_n_ff;
    assign rx_data_ready_n = rx_data_ready_n_n_ff;
endmodule : uart_hold
`default_nettype wire

// file: uart_hold_checker.sv
`timescale 1ns/10ps
`default_nettype none
module uart_hold_checker
    import uart_hold_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic modem_delta,
    input wire logic int_out,
    input wire logic tx_space_ready_n,
    input wire logic rx_data_ready_n
);
    // shadows of the host-written control bits
    logic [3:0] mask_ff;
    logic lock_ff;
    logic fen_ff;
    logic dma_ff;
    wire logic mode0 = !(fen_ff && dma_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_ff <= 4'h0;
            lock_ff <= 1'b0;
            fen_ff <= 1'b0;
            dma_ff <= 1'b0;
        end else if (bus_wr) begin
            if (bus_addr == ADR_IRQ_MASK && !lock_ff) mask_ff <= bus_wdata[3:0];
            if (bus_addr == ADR_LINE_CTL) lock_ff <= bus_wdata[LC_DIV_ACCESS];
            if (bus_addr == ADR_FIFO_CTL) fen_ff <= bus_wdata[FC_ENABLE];
            if (bus_addr == ADR_FIFO_CTL) dma_ff <= bus_wdata[FC_DMA_MODE];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_stat_rd;
        bus_rd && bus_addr == ADR_LINE_STAT ##1 1'b1;
    endsequence
    // ready pins steady around the status read
    sequence s_mode0_rd;
        (bus_rd && bus_addr == ADR_LINE_STAT && mode0 && $stable(rx_data_ready_n) && $stable(tx_space_ready_n))
        ##1 ($stable(rx_data_ready_n) && $stable(tx_space_ready_n));
    endsequence

    property p_polled;
        (mask_ff == 4'h0) [*3] |-> !int_out;
    endproperty
    property p_modem;
        (mask_ff == 4'h8 && modem_delta) [*3] |-> int_out;
    endproperty
    property p_mask_rd;
        bus_rd && bus_addr == ADR_IRQ_MASK && !lock_ff |=> bus_rdata == {4'h0, mask_ff};
    endproperty
    property p_locked;
        bus_rd && bus_addr <= ADR_IRQ_MASK && lock_ff |=> bus_rdata == ZERO_BYTE;
    endproperty
    property p_all_empty;
        s_stat_rd |-> !bus_rdata[6] || bus_rdata[5];
    endproperty
    property p_err_data;
        s_stat_rd |-> !bus_rdata[7] || bus_rdata[0];
    endproperty
    property p_rx_ready0;
        s_mode0_rd |-> bus_rdata[0] == !rx_data_ready_n;
    endproperty
    property p_tx_ready0;
        s_mode0_rd |-> (fen_ff ? (!bus_rdata[5] || !tx_space_ready_n) : (bus_rdata[5] == !tx_space_ready_n));
    endproperty

    a_polled: assert property (p_polled) else $error("interrupt with all mask bits clear");
    a_modem: assert property (p_modem) else $error("modem interrupt missing");
    a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
    a_locked: assert property (p_locked) else $error("register visible while locked");
    a_all_empty: assert property (p_all_empty) else $error("all empty without holding empty");
    a_err_data: assert property (p_err_data) else $error("error flag with empty buffer");
    a_rx_ready0: assert property (p_rx_ready0) else $error("rx ready disagrees with data ready");
    a_tx_ready0: assert property (p_tx_ready0) else $error("tx ready disagrees with holding empty");
endmodule : uart_hold_checker

bind uart_hold uart_hold_checker u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .serial_in(serial_in), .serial_out(serial_out),
    .modem_delta(modem_delta), .int_out(int_out), .tx_space_ready_n(tx_space_ready_n),
    .rx_data_ready_n(rx_data_ready_n));
`default_nettype wire

// file: serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer
    import uart_hold_pkg::*;
(
    input wire logic clk,
    input wire logic serial_out,
    output logic serial_in
);
    localparam int BIT_CLKS = OVS_DIV * OVS_RATE;
    logic [7:0] got_q[$];
    logic [7:0] shift;

    task automatic wait_clks(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clks

    // a low stop bit makes a framing fault; line returns high afterwards
    task automatic send(input logic [7:0] b, input logic stop_bit);
        logic [9:0] frame;
        frame = {stop_bit, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            #1 serial_in = frame[i];
            wait_clks(BIT_CLKS);
        end
        #1 serial_in = 1'b1;
        wait_clks(BIT_CLKS);
    endtask : send

    // low pulse well short of half a bit
    task automatic glitch();
        @(posedge clk);
        #1 serial_in = 1'b0;
        wait_clks(3 * OVS_DIV);
        #1 serial_in = 1'b1;
        wait_clks(BIT_CLKS);
    endtask : glitch

    initial begin
        serial_in = 1'b1;
        forever begin
            @(negedge serial_out);
            wait_clks(BIT_CLKS / 2);
            for (int i = 0; i < 8; i++) begin
                wait_clks(BIT_CLKS);
                shift[i] = serial_out;
            end
            wait_clks(BIT_CLKS);
            got_q.push_back(shift);
        end
    end
endmodule : serial_peer
`default_nettype wire

// file: uart_hold_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uart_hold_tb import uart_hold_pkg::*; ;
    localparam int BIT_CLKS = OVS_DIV * OVS_RATE;
    logic clk, rst, bus_wr, bus_rd, modem_delta;
    logic [2:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic serial_in, serial_out, int_out, tx_space_ready_n, rx_data_ready_n;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    uart_hold DUT (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .serial_in(serial_in), .serial_out(serial_out),
        .modem_delta(modem_delta), .int_out(int_out), .tx_space_ready_n(tx_space_ready_n),
        .rx_data_ready_n(rx_data_ready_n));
    serial_peer peer (.clk(clk), .serial_out(serial_out), .serial_in(serial_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_errors++;
            $display("MISMATCH t=%0t timeout", $time);
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(posedge clk);
        #1;
        bus_wr = 1'b0;
    endtask : wr

    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk);
        #1;
        bus_rd = 1'b0;
        chk(bus_rdata, exp, what);
    endtask : rdc

    task automatic wait_int(input logic exp);
        for (int n = 0; n < 30 && int_out !== exp; n++) @(posedge clk);
        #1;
        chk({7'h0, int_out}, {7'h0, exp}, "int_out");
    endtask : wait_int

    initial begin
        rst = 1'b1;
        bus_addr = 3'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        modem_delta = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        rdc(ADR_LINE_STAT, 8'h60, "status rst");
        rdc(ADR_FIFO_CTL, 8'h01, "source rst");
        rdc(ADR_IRQ_MASK, IRQ_MASK_RST, "mask rst");
        rdc(3'h4, ZERO_BYTE, "unmapped");
        chk({7'h0, rx_data_ready_n}, 8'h01, "rx ready rst");
        $display("test reset done");
        wr(ADR_IRQ_MASK, 8'h02);
        wait_int(1'b1);
        wr(ADR_IRQ_MASK, 8'h00);
        wait_int(1'b0);
        wr(ADR_LINE_CTL, 8'h80);
        wr(ADR_IRQ_MASK, 8'h0f);
        rdc(ADR_IRQ_MASK, ZERO_BYTE, "locked mask");
        wr(ADR_LINE_CTL, LINE_CTL_RST);
        rdc(ADR_IRQ_MASK, ZERO_BYTE, "mask kept");
        modem_delta = 1'b1;
        repeat (3) @(posedge clk);
        wait_int(1'b0);
        wr(ADR_IRQ_MASK, 8'h08);
        wait_int(1'b1);
        wr(ADR_IRQ_MASK, 8'h00);
        modem_delta = 1'b0;
        $display("test mask done");
        // one byte goes to the shifter, eight fill the buffer, the tenth is dropped
        wr(ADR_FIFO_CTL, 8'h01);
        for (int i = 0; i < 10; i++) wr(ADR_HOLD, 8'h30 + 8'(i));
        rdc(ADR_LINE_STAT, 8'h00, "status full");
        chk({7'h0, tx_space_ready_n}, 8'h01, "tx ready full");
        wr(ADR_FIFO_CTL, 8'h05);
        rdc(ADR_LINE_STAT, 8'h20, "shifter busy");
        for (int n = 0; n < 12 * BIT_CLKS && peer.got_q.size() == 0; n++) @(posedge clk);
        chk(peer.got_q[0], 8'h30, "sent byte");
        repeat (BIT_CLKS) @(posedge clk);
        rdc(ADR_LINE_STAT, 8'h60, "tx all empty");
        chk(8'(peer.got_q.size()), 8'h01, "sent count");
        $display("test transmit done");
        wr(ADR_FIFO_CTL, 8'h49);
        wr(ADR_IRQ_MASK, 8'h01);
        peer.glitch();
        repeat (10 * BIT_CLKS) @(posedge clk);
        rdc(ADR_LINE_STAT, 8'h60, "false start");
        peer.send(8'ha5, 1'b1);
        rdc(ADR_LINE_STAT, 8'h61, "one char");
        wait_int(1'b0);
        chk({7'h0, rx_data_ready_n}, 8'h01, "below trigger");
        peer.send(8'h5a, 1'b1);
        wait_int(1'b1);
        rdc(ADR_FIFO_CTL, {2'b11, 2'b00, SRC_RX_DATA, 1'b0}, "source trigger");
        chk({7'h0, rx_data_ready_n}, 8'h00, "at trigger");
        rdc(ADR_HOLD, 8'ha5, "oldest");
        wait_int(1'b0);
        rdc(ADR_FIFO_CTL, 8'hc1, "source clear");
        rdc(ADR_HOLD, 8'h5a, "second");
        rdc(ADR_LINE_STAT, 8'h60, "drained");
        chk({7'h0, rx_data_ready_n}, 8'h01, "rx ready empty");
        $display("test receive done");
        wr(ADR_IRQ_MASK, 8'h04);
        peer.send(8'h00, 1'b0);
        wait_int(1'b1);
        rdc(ADR_FIFO_CTL, {2'b11, 2'b00, SRC_LINE_STAT, 1'b0}, "source line");
        rdc(ADR_LINE_STAT, 8'hf9, "break");
        rdc(ADR_HOLD, 8'h00, "bad byte");
        wait_int(1'b0);
        rdc(ADR_LINE_STAT, 8'h60, "error gone");
        $display("test error done");
        results();
    end
endmodule : uart_hold_tb
`default_nettype wire
